// ---- rtl/obdc_params.svh ----
// Offsets, field positions, reset values and pin table for the bank C control block
`ifndef OBDC_PARAMS_SVH
`define OBDC_PARAMS_SVH

`define OBDC_ADDR_DIV      8'h20
`define OBDC_ADDR_RSVD_A   8'h21
`define OBDC_ADDR_PWR_SRC  8'h22
`define OBDC_ADDR_RSVD_B   8'h23
`define OBDC_ADDR_OUT0_PD  8'h24
`define OBDC_ADDR_OUT1_PD  8'h25

`define OBDC_BANK_PD_BIT   7
`define OBDC_CFG_SRC_BIT   0
`define OBDC_OUT_PD_BIT    7

`define OBDC_DIV_RST       6'h0d
`define OBDC_DIV_MIN       6'h02
`define OBDC_DIV_MAX       6'h3b
`define OBDC_BANK_PD_RST   1'b0
`define OBDC_CFG_SRC_RST   1'b0
`define OBDC_OUT_PD_RST    2'h0
`define OBDC_RATIO_RST     8'h10

// Divider code and bank power-down chosen by each setting of the two select pins
`define OBDC_PIN_CODE_0    6'h0d
`define OBDC_PIN_CODE_1    6'h09
`define OBDC_PIN_CODE_2    6'h07
`define OBDC_PIN_CODE_3    6'h0d
`define OBDC_PIN_PD_MASK   4'h8

`endif

// ---- rtl/obdc_pkg.sv ----
// Types shared by the bank C control block
package obdc_pkg;

  typedef struct packed {
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic [5:0] divCode;
    logic       bankPd;
    logic       cfgSource;
    logic [1:0] outPd;
    logic       applyPrev;
    logic [5:0] activeCode;
    logic [7:0] activeRatio;
    logic       bankPdOut;
    logic [1:0] outPdOut;
    logic [7:0] rdData;
  } obdc_state_t;

endpackage

// ---- rtl/obdc_ratio_if.sv ----
// Carrier between the control block and its divider ratio lookup
`timescale 1ns/100ps
interface obdc_ratio_if;
  logic [5:0] code;
  logic [7:0] ratio;
  logic       reserved;

  modport requester (output code, input ratio, input reserved);
  modport lookup    (input code, output ratio, output reserved);
endinterface

// ---- rtl/obdc_ratio_lut.sv ----
// Divider code to divide ratio lookup
`timescale 1ns/100ps
`include "obdc_params.svh"
module obdc_ratio_lut
(
  obdc_ratio_if.lookup rif
);

  // Index is code minus two; table ascends strictly
  localparam logic [7:0] RATIO_TAB [0:57] = '{
    8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0e,
    8'h0f, 8'h10, 8'h12, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1b, 8'h1c,
    8'h1e, 8'h20, 8'h21, 8'h23, 8'h24, 8'h28, 8'h2a, 8'h2c, 8'h2d, 8'h30,
    8'h32, 8'h36, 8'h37, 8'h38, 8'h3c, 8'h40, 8'h42, 8'h46, 8'h48, 8'h50,
    8'h54, 8'h58, 8'h5a, 8'h60, 8'h64, 8'h6c, 8'h6e, 8'h70, 8'h78, 8'h80,
    8'h84, 8'h8c, 8'h90, 8'ha0, 8'hb0, 8'hb4, 8'hc8, 8'hdc
  };

  logic [5:0] index;

  assign rif.reserved = (rif.code < `OBDC_DIV_MIN) || (rif.code > `OBDC_DIV_MAX);
  assign index        = rif.code - `OBDC_DIV_MIN;
  assign rif.ratio    = rif.reserved ? 8'h00 : RATIO_TAB[index];

endmodule

// ---- rtl/obdc_bank_ctrl.sv ----
// Bank C divider, power-down and configuration source control registers
`timescale 1ns/100ps
`include "obdc_params.svh"

//
// Contract
// - Six-bit divider code, resets to divide sixteen
// - New divider waits for apply bit toggle
// - Bank power-down low keeps bank running
// - Bank power-down high stops bank and outputs
// - Source bit low: pins set divider, power-down
// - Source bit high: registers set divider, power-down
// - Each output has own power-down bit
// - Reserved bits read undefined; here zero
module obdc_bank_ctrl
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       applyToggle,
  input  wire logic [1:0] bankSelPin,
  output logic      [5:0] activeDivCode,
  output logic      [7:0] activeDivRatio,
  output logic            bankPowerdown,
  output logic      [1:0] outputPowerdown
);

  obdc_pkg::obdc_state_t st;
  obdc_pkg::obdc_state_t next_st;
  obdc_ratio_if          rif ();

  logic [5:0] pinCode;
  logic       pinPd;
  logic [5:0] effCode;
  logic       effPd;
  logic       applyEdge;
  logic [7:0] rdMux;
  localparam logic [3:0] PIN_PD_MASK = `OBDC_PIN_PD_MASK;

  obdc_ratio_lut u_ratio_lut
  (
    .rif (rif)
  );

  // Pin table; synchronised copy only
  always_comb
  begin
    unique case (st.pinSync)
      2'h0:    pinCode = `OBDC_PIN_CODE_0;
      2'h1:    pinCode = `OBDC_PIN_CODE_1;
      2'h2:    pinCode = `OBDC_PIN_CODE_2;
      2'h3:    pinCode = `OBDC_PIN_CODE_3;
    endcase
  end

  assign pinPd = PIN_PD_MASK[st.pinSync];

  // Source chosen before apply so a mode switch can be applied at once
  assign effCode   = st.cfgSource ? st.divCode : pinCode;
  assign effPd     = st.cfgSource ? st.bankPd : pinPd;
  assign rif.code  = effCode;
  assign applyEdge = applyToggle ^ st.applyPrev;

  // Reserved bits read as zero
  always_comb
  begin
    rdMux = 8'h00;
    unique case (regAddr)
      `OBDC_ADDR_DIV:     rdMux[5:0] = st.divCode;
      `OBDC_ADDR_PWR_SRC:
      begin
        rdMux[`OBDC_BANK_PD_BIT] = st.bankPd;
        rdMux[`OBDC_CFG_SRC_BIT] = st.cfgSource;
      end
      `OBDC_ADDR_OUT0_PD: rdMux[`OBDC_OUT_PD_BIT] = st.outPd[0];
      `OBDC_ADDR_OUT1_PD: rdMux[`OBDC_OUT_PD_BIT] = st.outPd[1];
      default:            rdMux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_st = st;
    if (clkEn)
    begin
      next_st.pinMeta = bankSelPin;
      next_st.pinSync = st.pinMeta;
      if (regWrEn)
      begin
        // Reserved bit positions are dropped on write
        unique case (regAddr)
          `OBDC_ADDR_DIV:     next_st.divCode = regWrData[5:0];
          `OBDC_ADDR_PWR_SRC:
          begin
            next_st.bankPd    = regWrData[`OBDC_BANK_PD_BIT];
            next_st.cfgSource = regWrData[`OBDC_CFG_SRC_BIT];
          end
          `OBDC_ADDR_OUT0_PD: next_st.outPd[0] = regWrData[`OBDC_OUT_PD_BIT];
          `OBDC_ADDR_OUT1_PD: next_st.outPd[1] = regWrData[`OBDC_OUT_PD_BIT];
          default:            next_st.outPd = st.outPd;
        endcase
      end
      if (regRdEn)
      begin
        next_st.rdData = rdMux;
      end
      next_st.applyPrev = applyToggle;
      // A reserved code is never applied; the old ratio keeps running
      if (applyEdge && !rif.reserved)
      begin
        next_st.activeCode  = effCode;
        next_st.activeRatio = rif.ratio;
      end
      next_st.bankPdOut = effPd;
      next_st.outPdOut  = {2{effPd}} | st.outPd;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st.pinMeta     <= 2'h0;
      st.pinSync     <= 2'h0;
      st.divCode     <= `OBDC_DIV_RST;
      st.bankPd      <= `OBDC_BANK_PD_RST;
      st.cfgSource   <= `OBDC_CFG_SRC_RST;
      st.outPd       <= `OBDC_OUT_PD_RST;
      st.applyPrev   <= 1'b0;
      st.activeCode  <= `OBDC_DIV_RST;
      st.activeRatio <= `OBDC_RATIO_RST;
      st.bankPdOut   <= 1'b0;
      st.outPdOut    <= 2'h0;
      st.rdData      <= 8'h00;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign regRdData       = st.rdData;
  assign activeDivCode   = st.activeCode;
  assign activeDivRatio  = st.activeRatio;
  assign bankPowerdown   = st.bankPdOut;
  assign outputPowerdown = st.outPdOut;

  a_div_range: assert property (@(posedge core_clk) disable iff (!rst_b)
    (activeDivCode >= 6'h02) && (activeDivCode <= 6'h3b))
    else $error("Active divider code is reserved");

  a_ratio_top: assert property (@(posedge core_clk) disable iff (!rst_b)
    ((activeDivCode == 6'h3b) |-> (activeDivRatio == 8'hdc)) and
    ((activeDivCode == 6'h0d) |-> (activeDivRatio == 8'h10)))
    else $error("Divider ratio does not match code");

  a_div_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(clkEn && applyEdge) |=> $stable(activeDivCode) && $stable(activeDivRatio))
    else $error("Divider changed without apply toggle");

  a_div_apply: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && applyEdge && !rif.reserved) |=> (activeDivCode == $past(effCode)))
    else $error("Apply toggle did not load divider");

  a_bank_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && !effPd) |=> !bankPowerdown)
    else $error("Bank powered down while enabled");

  a_bank_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && effPd) |=> bankPowerdown && (outputPowerdown == 2'h3))
    else $error("Bank power-down missed an output");

  a_pin_source: assert property (@(posedge core_clk) disable iff (!rst_b)
    !st.cfgSource |-> (effCode == pinCode) && (effPd == pinPd))
    else $error("Pin source not used");

  a_reg_source: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.cfgSource |-> (effCode == st.divCode) && (effPd == st.bankPd))
    else $error("Register source not used");

  a_out_pd: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && !effPd) |=> (outputPowerdown == $past(st.outPd)))
    else $error("Output power-down mismatch");

  a_rsvd_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && regRdEn && (regAddr == 8'h22)) |=> (regRdData[6:1] == 6'h00))
    else $error("Reserved bits read nonzero");

  a_src_switch: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && regWrEn && (regAddr == 8'h22) && regWrData[0] && (st.divCode == effCode))
    |=> st.cfgSource)
    else $error("Source bit not stored");

  a_pin_table: assert property (@(posedge core_clk) disable iff (!rst_b)
    !st.cfgSource |-> (effPd == (st.pinSync == 2'h3)))
    else $error("Pin power-down table mismatch");

  a_pin_code: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!st.cfgSource && (st.pinSync == 2'h2)) |-> (effCode == 6'h07))
    else $error("Pin divider table mismatch");

  a_div_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && regWrEn && (regAddr == 8'h20)) |=> (st.divCode == $past(regWrData[5:0])))
    else $error("Divider code write not stored");

  a_out1_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    (clkEn && regWrEn && (regAddr == 8'h25)) |=> (st.outPd[1] == $past(regWrData[7])))
    else $error("Output power-down write not stored");

  a_freeze_state: assert property (@(posedge core_clk) disable iff (!rst_b)
    !clkEn |=> $stable(st))
    else $error("State moved while clock enable low");

endmodule

// ---- sim/obdc_host_model.sv ----
// Host model driving the bank C register strobes and apply bit
`timescale 1ns/100ps
module obdc_host_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic            applyToggle
);
  initial
  begin
    regAddr     = 8'h00;
    regWrData   = 8'h00;
    regWrEn     = 1'b0;
    regRdEn     = 1'b0;
    applyToggle = 1'b0;
  end

  // Callers keep reserved bits zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(posedge core_clk);
    #1;
    d = regRdData;
  endtask

  // Divider only moves after this toggle
  task automatic apply();
    @(posedge core_clk);
    applyToggle <= ~applyToggle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
endmodule

// ---- sim/test_output_bank_divider_control.sv ----
// Self-checking bench for the bank C control block
`timescale 1ns/100ps
module test_output_bank_divider_control;
  logic       core_clk;
  logic       rst_b;
  logic       clkEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic       applyToggle;
  logic [1:0] bankSelPin;
  logic [5:0] activeDivCode;
  logic [7:0] activeDivRatio;
  logic       bankPowerdown;
  logic [1:0] outputPowerdown;
  logic [7:0] rdVal;
  int         err_total;
  int         comparisons;
  int         cycleCount;

  obdc_bank_ctrl u_obdc_bank_ctrl (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .applyToggle(applyToggle), .bankSelPin(bankSelPin),
    .activeDivCode(activeDivCode), .activeDivRatio(activeDivRatio),
    .bankPowerdown(bankPowerdown), .outputPowerdown(outputPowerdown));

  obdc_host_model u_obdc_host_model (.core_clk(core_clk), .regRdData(regRdData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .applyToggle(applyToggle));

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cycleCount++;
    if (cycleCount == 4000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic outs(input logic [5:0] c, input logic [7:0] r, input logic b,
                      input logic [1:0] o);
    chk("code", {2'h0, c}, {2'h0, activeDivCode});
    chk("ratio", r, activeDivRatio);
    chk("bank pd", {7'h0, b}, {7'h0, bankPowerdown});
    chk("out pd", {6'h0, o}, {6'h0, outputPowerdown});
  endtask

  task automatic pins(input logic [1:0] p);
    @(posedge core_clk);
    bankSelPin <= p;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic t_reset();
    outs(6'h0d, 8'h10, 1'b0, 2'h0);
    u_obdc_host_model.rd(8'h20, rdVal);
    chk("div reg", 8'h0d, rdVal);
    u_obdc_host_model.rd(8'h22, rdVal);
    chk("pd src reg", 8'h00, rdVal);
    u_obdc_host_model.rd(8'h25, rdVal);
    chk("out1 reg", 8'h00, rdVal);
    u_obdc_host_model.rd(8'h21, rdVal);
    chk("rsvd reg", 8'h00, rdVal);
  endtask

  task automatic t_pins();
    pins(2'h2);
    u_obdc_host_model.apply();
    outs(6'h07, 8'h08, 1'b0, 2'h0);
    pins(2'h1);
    u_obdc_host_model.apply();
    outs(6'h09, 8'h0a, 1'b0, 2'h0);
    pins(2'h3);
    outs(6'h09, 8'h0a, 1'b1, 2'h3);
    pins(2'h0);
    outs(6'h09, 8'h0a, 1'b0, 2'h0);
  endtask

  task automatic t_regs();
    u_obdc_host_model.wr(8'h22, 8'h01);
    u_obdc_host_model.wr(8'h20, 8'h3b);
    u_obdc_host_model.rd(8'h20, rdVal);
    chk("div reg", 8'h3b, rdVal);
    outs(6'h09, 8'h0a, 1'b0, 2'h0);
    u_obdc_host_model.apply();
    outs(6'h3b, 8'hdc, 1'b0, 2'h0);
    pins(2'h3);
    outs(6'h3b, 8'hdc, 1'b0, 2'h0);
    pins(2'h0);
    u_obdc_host_model.wr(8'h20, 8'h3c);
    u_obdc_host_model.apply();
    outs(6'h3b, 8'hdc, 1'b0, 2'h0);
    u_obdc_host_model.wr(8'h20, 8'h02);
    u_obdc_host_model.apply();
    outs(6'h02, 8'h02, 1'b0, 2'h0);
  endtask

  task automatic t_powerdown();
    u_obdc_host_model.wr(8'h24, 8'h80);
    repeat (2) @(posedge core_clk);
    #1;
    outs(6'h02, 8'h02, 1'b0, 2'h1);
    u_obdc_host_model.wr(8'h22, 8'h81);
    repeat (2) @(posedge core_clk);
    #1;
    outs(6'h02, 8'h02, 1'b1, 2'h3);
    u_obdc_host_model.wr(8'h25, 8'h80);
    u_obdc_host_model.wr(8'h22, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    outs(6'h02, 8'h02, 1'b0, 2'h3);
    u_obdc_host_model.rd(8'h24, rdVal);
    chk("out0 reg", 8'h80, rdVal);
  endtask

  // Frozen block must ignore writes and apply until enable returns
  task automatic t_freeze();
    @(posedge core_clk);
    clkEn <= 1'b0;
    u_obdc_host_model.wr(8'h22, 8'h81);
    u_obdc_host_model.wr(8'h20, 8'h09);
    u_obdc_host_model.apply();
    outs(6'h02, 8'h02, 1'b0, 2'h3);
    @(posedge core_clk);
    clkEn <= 1'b1;
    u_obdc_host_model.rd(8'h20, rdVal);
    chk("div frozen", 8'h02, rdVal);
    u_obdc_host_model.rd(8'h22, rdVal);
    chk("pd src frozen", 8'h01, rdVal);
  endtask

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    core_clk   = 1'b0;
    rst_b      = 1'b0;
    clkEn      = 1'b1;
    bankSelPin = 2'h0;
    err_total  = 0;
    comparisons = 0;
    cycleCount = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset();
    t_pins();
    t_regs();
    t_powerdown();
    t_freeze();
    final_report();
  end
endmodule
